/* virtual_address_translation.sv */
// Translation block: joint pair buffer, fetch-side buffer, segment and privilege decode, control registers.
// Assumes requests and register strobes come from logic on the same clock.
`timescale 1ns/1ps
`include "mmu_defs.svh"

// Summary of operation
// - Joint buffer is fully associative, serves fetch and data, 64 pairs map 128 pages.
// - Page sizes 4KB to 16MB by fours; mask register stored with each entry write.
// - One page size in use at a time; mixed sizes are not required.
// - A random entry can be chosen as the target of a new mapping.
// - Random choice never lands on the configured count of locked low entries while that count is at most 63.
// - Each page carries attribute bits: uncached, write-back, or uncached accelerated.
// - Unmapped compatibility segments take the low 29 address bits, zero-extended.
// - Eight-entry fetch buffer maps one page per entry using the mask register size.
// - Fetch buffer miss refills a random entry from the joint buffer, invisibly.
// - Match needs equal page number and either global bit or equal space identifier.
// - Hit joins the frame number with the untranslated page offset.
// - No match raises a translation miss so software can refill.
// - Multiple matches are undefined; software must never create overlaps.
// - Current space identifier is 8 bits from the entry high register; entries hold global.
// - Privilege field 10 user, 01 supervisor, 00 kernel; only kernel may change it.
// - Exception or error level forces kernel; error level takes precedence.
// - Physical addresses are 36 bits wide, 64 gigabytes.
// - Only 64-bit addressing, 32-bit compatible, little-endian byte order.
// - User segment from zero spans one terabyte, reachable from all modes, always mapped.
// - 4KB pages use 12-bit offset, 16MB pages a 24-bit offset.
// - User address with bits 63:40 not all zero raises an address error.
module virtual_address_translation (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Instruction fetch translation.
  input wire mmu_pkg::req_s iReq,
  output mmu_pkg::resp_s iResp,
  // Load and store translation.
  input wire mmu_pkg::req_s dReq,
  output mmu_pkg::resp_s dResp,
  // Register port.
  input wire logic [`REG_AW-1:0] regAddr,
  input wire logic [`REG_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`REG_DW-1:0] regRdata,
  // Current privilege.
  output mmu_pkg::mode_e privMode
);

  mmu_pkg::mmu_state_s s_q;
  mmu_pkg::mmu_state_s s_d;
  mmu_pkg::mode_e mode;
  logic iHit;
  mmu_pkg::ientry_s iEntry;
  logic iFill;
  mmu_pkg::ientry_s iFillEntry;
  logic jWrite;
  logic [5:0] wIdx;
  logic [6:0] dFind;
  logic [6:0] iFind;
  logic [1:0] dClass;

  function automatic mmu_pkg::mode_e privOf(input logic [1:0] privilege_select_field, input logic exception_level_bit, input logic error_level_bit);
    if (error_level_bit || exception_level_bit)
    begin
      return mmu_pkg::MODE_KERNEL;
    end
    else if (privilege_select_field == 2'h2)
    begin
      return mmu_pkg::MODE_USER;
    end
    else if (privilege_select_field == 2'h1)
    begin
      return mmu_pkg::MODE_SUPER;
    end
    else if (privilege_select_field == 2'h0)
    begin
      return mmu_pkg::MODE_KERNEL;
    end
    else
    begin
      return mmu_pkg::MODE_USER;
    end
  endfunction : privOf

  // Returns {unmapped, address error} for a virtual address in the given mode.
  function automatic logic [1:0] classify(input logic [63:0] va, input mmu_pkg::mode_e m);
    logic unm;
    logic err;
    unm = (m == mmu_pkg::MODE_KERNEL) && (&va[63:31]) && !va[30];
    err = 1'b0;
    if (m == mmu_pkg::MODE_USER)
    begin
      err = |va[63:40];
    end
    else if (m == mmu_pkg::MODE_SUPER)
    begin
      err = !((!va[63] && va[61:40] == 22'h000000) || ((&va[63:30]) && !va[29]));
    end
    return {unm, err};
  endfunction : classify

  // Returns {hit, pair index}; with overlapping entries the highest index wins.
  function automatic logic [6:0] jtlbFind(input logic [63:0] va);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < `JOINT_TRANSLATION_BUFFER_PAIRS; i++)
    begin
      if (mmu_pkg::vaMatch(va, s_q.joint_translation_buffer[i].region, {s_q.joint_translation_buffer[i].vpn2, 1'b0}, {15'h0000, s_q.joint_translation_buffer[i].mask, 1'b1},
                           s_q.joint_translation_buffer[i].space_identifier, s_q.joint_translation_buffer[i].global, s_q.space_identifier))
      begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction : jtlbFind

  // Answer built from the joint buffer, or from the unmapped segment rule.
  function automatic mmu_pkg::resp_s jtlbAnswer(input logic [63:0] va, input logic [1:0] cls, input logic [6:0] f);
    mmu_pkg::resp_s r;
    mmu_pkg::jentry_s e;
    mmu_pkg::half_s h;
    r = '0;
    e = s_q.joint_translation_buffer[f[5:0]];
    h = mmu_pkg::oddSelect(va, e.mask) ? e.odd : e.even;
    r.valid = 1'b1;
    if (cls[0])
    begin
      r.addrErr = 1'b1;
    end
    else if (cls[1])
    begin
      r.paddr = {7'h00, va[28:0]};
      r.attr = va[29] ? `ATTR_UNCACHED : `ATTR_WRITEBACK;
    end
    else if (f[6] && h.valid)
    begin
      r.paddr = mmu_pkg::physAddr(va, h.pfn, e.mask);
      r.attr = h.attr;
    end
    else
    begin
      r.miss = 1'b1;
    end
    return r;
  endfunction : jtlbAnswer

  instruction_translation_buffer instruction_translation_buffer_i (
    .clk(clk),
    .nrst(nrst),
    .lookVa(iReq.vaddr),
    .curAsid(s_q.space_identifier),
    .hit(iHit),
    .hitEntry(iEntry),
    .fill(iFill),
    .fillEntry(iFillEntry),
    .flush(jWrite)
  );

  always_comb
  begin
    mmu_pkg::jentry_s ne;
    mmu_pkg::jentry_s fe;
    logic [1:0] iClass;
    ne = '0;
    fe = '0;
    iClass = 2'h0;
    s_d = s_q;
    s_d.iResp = '0;
    s_d.dResp = '0;
    s_d.rdata = '0;
    mode = privOf(s_q.privilege_select_field, s_q.exception_level_bit, s_q.error_level_bit);
    iFill = 1'b0;
    iFillEntry = '0;
    jWrite = 1'b0;
    wIdx = s_q.index;
    // The random index walks down and wraps above the locked entries.
    if ({1'b0, s_q.random} <= s_q.locked || s_q.random == 6'h00)
    begin
      s_d.random = `RST_RANDOM;
    end
    else
    begin
      s_d.random = s_q.random - 6'h01;
    end
    dClass = classify(dReq.vaddr, mode);
    dFind = jtlbFind(dReq.vaddr);
    if (dReq.valid)
    begin
      s_d.dResp = jtlbAnswer(dReq.vaddr, dClass, dFind);
    end
    iClass = classify(iReq.vaddr, mode);
    iFind = jtlbFind(iReq.vaddr);
    if (iReq.valid)
    begin
      if (iClass == 2'h0 && iHit)
      begin
        s_d.iResp.valid = 1'b1;
        s_d.iResp.paddr = mmu_pkg::physAddr(iReq.vaddr, iEntry.pfn, iEntry.mask);
        s_d.iResp.attr = iEntry.attr;
      end
      else
      begin
        s_d.iResp = jtlbAnswer(iReq.vaddr, iClass, iFind);
        fe = s_q.joint_translation_buffer[iFind[5:0]];
        if (iClass == 2'h0 && !s_d.iResp.miss)
        begin
          iFill = 1'b1;
        end
        iFillEntry.valid = 1'b1;
        iFillEntry.region = fe.region;
        iFillEntry.virtual_page_number = iReq.vaddr[39:12];
        iFillEntry.mask = s_q.mask;
        iFillEntry.space_identifier = fe.space_identifier;
        iFillEntry.global = fe.global;
        iFillEntry.pfn = mmu_pkg::oddSelect(iReq.vaddr, fe.mask) ? fe.odd.pfn : fe.even.pfn;
        iFillEntry.attr = s_d.iResp.attr;
      end
    end
    // Register writes.
    if (regWr)
    begin
      if (regAddr == `OFF_INDEX)
      begin
        s_d.index = regWdata[5:0];
      end
      else if (regAddr == `OFF_LO0)
      begin
        s_d.lo0 = regWdata[`LO_PFN_LSB+`PFN_W-1:`LO_G_BIT+1];
        s_d.lo0G = regWdata[`LO_G_BIT];
      end
      else if (regAddr == `OFF_LO1)
      begin
        s_d.lo1 = regWdata[`LO_PFN_LSB+`PFN_W-1:`LO_G_BIT+1];
        s_d.lo1G = regWdata[`LO_G_BIT];
      end
      else if (regAddr == `OFF_PAGE_SIZE_MASK_REG)
      begin
        s_d.mask = regWdata[`PM_MASK_LSB+`MASK_W-1:`PM_MASK_LSB];
      end
      else if (regAddr == `OFF_LOCKED)
      begin
        s_d.locked = regWdata[6:0];
        s_d.random = `RST_RANDOM;
      end
      else if (regAddr == `OFF_ENTRY_HIGH_REG)
      begin
        s_d.hiRegion = regWdata[`HI_REGION_LSB+1:`HI_REGION_LSB];
        s_d.hiVpn2 = regWdata[`HI_VPN2_LSB+`VPN2_W-1:`HI_VPN2_LSB];
        s_d.space_identifier = regWdata[`HI_SPACE_IDENTIFIER_LSB+`SPACE_IDENTIFIER_W-1:`HI_SPACE_IDENTIFIER_LSB];
      end
      else if (regAddr == `OFF_STATUS && mode == mmu_pkg::MODE_KERNEL)
      begin
        s_d.privilege_select_field = regWdata[`ST_KSU_LSB+1:`ST_KSU_LSB];
        s_d.exception_level_bit = regWdata[`ST_EXL_BIT];
        s_d.error_level_bit = regWdata[`ST_ERL_BIT];
      end
      else if (regAddr == `OFF_COMMAND)
      begin
        if (regWdata[`CMD_WR_INDEX_BIT] || regWdata[`CMD_WR_RANDOM_BIT])
        begin
          jWrite = 1'b1;
          wIdx = regWdata[`CMD_WR_RANDOM_BIT] ? s_q.random : s_q.index;
        end
        else if (regWdata[`CMD_RD_INDEX_BIT])
        begin
          fe = s_q.joint_translation_buffer[s_q.index];
          s_d.hiRegion = fe.region;
          s_d.hiVpn2 = fe.vpn2;
          s_d.space_identifier = fe.space_identifier;
          s_d.mask = fe.mask;
          s_d.lo0 = fe.even;
          s_d.lo1 = fe.odd;
          s_d.lo0G = fe.global;
          s_d.lo1G = fe.global;
        end
      end
    end
    if (jWrite)
    begin
      ne.region = s_q.hiRegion;
      ne.vpn2 = s_q.hiVpn2 & ~{15'h0000, s_q.mask};
      ne.mask = s_q.mask;
      ne.space_identifier = s_q.space_identifier;
      ne.global = s_q.lo0G & s_q.lo1G;
      ne.even = s_q.lo0;
      ne.odd = s_q.lo1;
      s_d.joint_translation_buffer[wIdx] = ne;
    end
    // Register reads, answered in the next cycle.
    if (regRd)
    begin
      if (regAddr == `OFF_INDEX)
      begin
        s_d.rdata = {58'h0, s_q.index};
      end
      else if (regAddr == `OFF_RANDOM)
      begin
        s_d.rdata = {58'h0, s_q.random};
      end
      else if (regAddr == `OFF_LO0)
      begin
        s_d.rdata = {34'h0, s_q.lo0, s_q.lo0G};
      end
      else if (regAddr == `OFF_LO1)
      begin
        s_d.rdata = {34'h0, s_q.lo1, s_q.lo1G};
      end
      else if (regAddr == `OFF_PAGE_SIZE_MASK_REG)
      begin
        s_d.rdata = {39'h0, s_q.mask, 13'h0};
      end
      else if (regAddr == `OFF_LOCKED)
      begin
        s_d.rdata = {57'h0, s_q.locked};
      end
      else if (regAddr == `OFF_ENTRY_HIGH_REG)
      begin
        s_d.rdata = {s_q.hiRegion, 22'h0, s_q.hiVpn2, 5'h0, s_q.space_identifier};
      end
      else if (regAddr == `OFF_STATUS)
      begin
        s_d.rdata = {59'h0, s_q.privilege_select_field, s_q.error_level_bit, s_q.exception_level_bit, 1'b0};
      end
      else if (regAddr == `OFF_MODE)
      begin
        s_d.rdata = {62'h0, mode};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.random <= `RST_RANDOM;
      s_q.locked <= `RST_LOCKED;
      s_q.privilege_select_field <= `RST_KSU;
      s_q.error_level_bit <= `RST_ERL;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign iResp = s_q.iResp;
  assign dResp = s_q.dResp;
  assign regRdata = s_q.rdata;
  assign privMode = mode;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  unmapped_pa_a: assert property (dReq.valid && dClass == 2'h2 |=>
                                  dResp.valid && dResp.paddr == {7'h00, $past(dReq.vaddr[28:0])} && !dResp.miss)
    else $error("Unmapped segment address not formed from low bits.");
  user_range_a: assert property (dReq.valid && mode == mmu_pkg::MODE_USER && |dReq.vaddr[63:40] |=>
                                 dResp.addrErr && !dResp.miss)
    else $error("User address above one terabyte not refused.");
  miss_raise_a: assert property (dReq.valid && dClass == 2'h0 && !dFind[6] |=> dResp.valid && dResp.miss)
    else $error("Lookup without a match did not raise a miss.");
  hit_offset_a: assert property (dReq.valid && dClass == 2'h0 && dFind[6] ##1 !dResp.miss |->
                                 dResp.paddr[11:0] == $past(dReq.vaddr[11:0]))
    else $error("Page offset did not bypass translation.");
  level_force_a: assert property (s_q.error_level_bit || s_q.exception_level_bit |-> privMode == mmu_pkg::MODE_KERNEL)
    else $error("Exception or error level did not force kernel.");
  field_mode_a: assert property (!s_q.error_level_bit && !s_q.exception_level_bit && s_q.privilege_select_field == 2'h1 |-> privMode == mmu_pkg::MODE_SUPER)
    else $error("Privilege field 01 did not select supervisor.");
  random_lock_a: assert property (s_q.locked <= 7'd63 |-> {1'b0, s_q.random} >= s_q.locked)
    else $error("Random index fell among locked entries.");
  mask_store_a: assert property (jWrite |=> s_q.joint_translation_buffer[$past(wIdx)].mask == $past(s_q.mask))
    else $error("Entry write did not store the page size.");
  user_reject_a: assert property (regWr && regAddr == `OFF_STATUS && mode != mmu_pkg::MODE_KERNEL |=>
                                  $stable(s_q.privilege_select_field))
    else $error("Privilege field changed outside kernel mode.");
  resp_time_a: assert property (iReq.valid |=> iResp.valid)
    else $error("Fetch translation answer missing one cycle later.");

  data_hit_c: cover property (dReq.valid && dFind[6] ##1 dResp.valid && !dResp.miss);
  fetch_fill_c: cover property (iFill ##1 iReq.valid && iHit);
  addr_err_c: cover property (dResp.addrErr);
  write_random_c: cover property (jWrite && regWdata[`CMD_WR_RANDOM_BIT]);

endmodule : virtual_address_translation

/* mmu_defs.svh */
// Constants of the address translation block: sizes, register offsets, field positions, reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef MMU_DEFS_SVH
`define MMU_DEFS_SVH

`define JOINT_TRANSLATION_BUFFER_PAIRS 64
`define INSTRUCTION_TRANSLATION_BUFFER_ENTRIES 8
`define SPACE_IDENTIFIER_W 8
`define PFN_W 24
`define VPN2_W 27
`define MASK_W 12
`define PA_W 36
`define REG_AW 4
`define REG_DW 64

`define OFF_INDEX 4'h0
`define OFF_RANDOM 4'h1
`define OFF_LO0 4'h2
`define OFF_LO1 4'h3
`define OFF_PAGE_SIZE_MASK_REG 4'h4
`define OFF_LOCKED 4'h5
`define OFF_ENTRY_HIGH_REG 4'h6
`define OFF_STATUS 4'h7
`define OFF_COMMAND 4'h8
`define OFF_MODE 4'h9

`define LO_G_BIT 0
`define LO_V_BIT 1
`define LO_D_BIT 2
`define LO_C_LSB 3
`define LO_PFN_LSB 6
`define HI_SPACE_IDENTIFIER_LSB 0
`define HI_VPN2_LSB 13
`define HI_REGION_LSB 62
`define PM_MASK_LSB 13
`define ST_EXL_BIT 1
`define ST_ERL_BIT 2
`define ST_KSU_LSB 3
`define CMD_WR_INDEX_BIT 0
`define CMD_WR_RANDOM_BIT 1
`define CMD_RD_INDEX_BIT 2

`define RST_RANDOM 6'h3f
`define RST_LOCKED 7'h00
`define RST_KSU 2'h0
`define RST_ERL 1'b1

`define ATTR_UNCACHED 3'h2
`define ATTR_WRITEBACK 3'h3
`define ATTR_ACCEL 3'h7

`endif

/* mmu_pkg.sv */
// Types and shared matching arithmetic of the address translation block.
// Assumes the constants header is on the include path.
`include "mmu_defs.svh"

package mmu_pkg;

  typedef enum logic [1:0] {MODE_KERNEL, MODE_SUPER, MODE_USER} mode_e;

  typedef struct packed {
    logic [`PFN_W-1:0] pfn;
    logic [2:0] attr;
    logic dirty;
    logic valid;
  } half_s;

  typedef struct packed {
    logic [1:0] region;
    logic [`VPN2_W-1:0] vpn2;
    logic [`MASK_W-1:0] mask;
    logic [`SPACE_IDENTIFIER_W-1:0] space_identifier;
    logic global;
    half_s even;
    half_s odd;
  } jentry_s;

  typedef struct packed {
    logic valid;
    logic [1:0] region;
    logic [27:0] virtual_page_number;
    logic [`MASK_W-1:0] mask;
    logic [`SPACE_IDENTIFIER_W-1:0] space_identifier;
    logic global;
    logic [`PFN_W-1:0] pfn;
    logic [2:0] attr;
  } ientry_s;

  typedef struct packed {
    logic valid;
    logic [63:0] vaddr;
  } req_s;

  typedef struct packed {
    logic valid;
    logic [`PA_W-1:0] paddr;
    logic [2:0] attr;
    logic miss;
    logic addrErr;
  } resp_s;

  typedef struct packed {
    ientry_s [`INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] e;
    logic [2:0] victim;
  } instruction_translation_buffer_state_s;

  typedef struct packed {
    jentry_s [`JOINT_TRANSLATION_BUFFER_PAIRS-1:0] joint_translation_buffer;
    half_s lo0;
    half_s lo1;
    logic lo0G;
    logic lo1G;
    logic [1:0] hiRegion;
    logic [`VPN2_W-1:0] hiVpn2;
    logic [`SPACE_IDENTIFIER_W-1:0] space_identifier;
    logic [`MASK_W-1:0] mask;
    logic [5:0] index;
    logic [6:0] locked;
    logic [5:0] random;
    logic [1:0] privilege_select_field;
    logic exception_level_bit;
    logic error_level_bit;
    logic [`REG_DW-1:0] rdata;
    resp_s iResp;
    resp_s dResp;
  } mmu_state_s;

  // Page number compare; ignored bits cover the page offset from bit 12 up.
  function automatic logic vaMatch(input logic [63:0] va, input logic [1:0] region, input logic [27:0] virtual_page_number,
                                   input logic [27:0] ignore, input logic [`SPACE_IDENTIFIER_W-1:0] space_identifier, input logic global,
                                   input logic [`SPACE_IDENTIFIER_W-1:0] curAsid);
    return (va[63:62] == region) && (((va[39:12] ^ virtual_page_number) & ~ignore) == 28'h0) && (global || space_identifier == curAsid);
  endfunction : vaMatch

  // Frame number joined with the untranslated offset of the current page size.
  function automatic logic [`PA_W-1:0] physAddr(input logic [63:0] va, input logic [`PFN_W-1:0] pfn,
                                                input logic [`MASK_W-1:0] mask);
    return {(pfn & ~{12'h000, mask}) | (va[35:12] & {12'h000, mask}), va[11:0]};
  endfunction : physAddr

  // The first page number bit above the offset picks the odd half of a pair.
  function automatic logic oddSelect(input logic [63:0] va, input logic [`MASK_W-1:0] mask);
    logic s;
    s = va[12];
    for (int i = 0; i < `MASK_W; i++)
    begin
      if (mask[i])
      begin
        s = va[13+i];
      end
    end
    return s;
  endfunction : oddSelect

endpackage : mmu_pkg

/* instruction_translation_buffer.sv */
// Small fetch-side translation buffer of single-page entries, refilled from the joint buffer.
// Assumes lookups and fills come from logic on the same clock.
`timescale 1ns/1ps
`include "mmu_defs.svh"

module instruction_translation_buffer (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Lookup.
  input wire logic [63:0] lookVa,
  input wire logic [`SPACE_IDENTIFIER_W-1:0] curAsid,
  output logic hit,
  output mmu_pkg::ientry_s hitEntry,
  // Refill and invalidate.
  input wire logic fill,
  input wire mmu_pkg::ientry_s fillEntry,
  input wire logic flush
);

  mmu_pkg::instruction_translation_buffer_state_s s_q;
  mmu_pkg::instruction_translation_buffer_state_s s_d;

  always_comb
  begin
    hit = 1'b0;
    hitEntry = '0;
    for (int i = 0; i < `INSTRUCTION_TRANSLATION_BUFFER_ENTRIES; i++)
    begin
      if (s_q.e[i].valid && mmu_pkg::vaMatch(lookVa, s_q.e[i].region, s_q.e[i].virtual_page_number, {16'h0000, s_q.e[i].mask},
                                             s_q.e[i].space_identifier, s_q.e[i].global, curAsid))
      begin
        hit = 1'b1;
        hitEntry = s_q.e[i];
      end
    end
  end

  always_comb
  begin
    s_d = s_q;
    s_d.victim = s_q.victim + 3'h1;
    if (flush)
    begin
      for (int i = 0; i < `INSTRUCTION_TRANSLATION_BUFFER_ENTRIES; i++)
      begin
        s_d.e[i].valid = 1'b0;
      end
    end
    else if (fill)
    begin
      s_d.e[s_q.victim] = fillEntry;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  instruction_translation_buffer_fill_a: assert property (fill && !flush |=> s_q.e[$past(s_q.victim)].valid)
    else $error("Refilled fetch entry is not valid.");
  instruction_translation_buffer_flush_a: assert property (flush |=> !hit)
    else $error("Fetch buffer hit right after an invalidate.");
  instruction_translation_buffer_fill_c: cover property (fill ##1 hit);

endmodule : instruction_translation_buffer

/* pipe_requester.sv */
// Model of a pipeline stage that asks the block for translations.
// Assumes the block answers one cycle after each request.
`timescale 1ns/1ps

module pipe_requester (
  // Clock.
  input wire logic clk,
  // Translation port.
  output mmu_pkg::req_s req,
  input wire mmu_pkg::resp_s resp
);
  initial req = '0;

  // One request for one cycle; the address is inverted while idle.
  task automatic go(input logic [63:0] va, output mmu_pkg::resp_s r);
    @(posedge clk);
    req <= '{valid: 1'b1, vaddr: va};
    @(posedge clk);
    req <= '{valid: 1'b0, vaddr: ~va};
    #1;
    r = resp;
  endtask : go

endmodule : pipe_requester

/* virtual_address_translation_bench.sv */
// Self-checking bench of the translation block.
// Assumes the pipeline models and the block share one clock.
`timescale 1ns/1ps
`include "mmu_defs.svh"

module virtual_address_translation_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  mmu_pkg::req_s iReq;
  mmu_pkg::req_s dReq;
  mmu_pkg::resp_s iResp;
  mmu_pkg::resp_s dResp;
  logic [3:0] regAddr = 4'h0;
  logic [63:0] regWdata = 64'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [63:0] regRdata;
  mmu_pkg::mode_e privMode;
  int n_fail = 0;
  int cmp_count = 0;

  always #2.5 clk = ~clk;

  virtual_address_translation virtual_address_translation_i (.clk(clk), .nrst(nrst), .iReq(iReq),
    .iResp(iResp), .dReq(dReq), .dResp(dResp), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .privMode(privMode));
  pipe_requester fetchPipe (.clk(clk), .req(iReq), .resp(iResp));
  pipe_requester dataPipe (.clk(clk), .req(dReq), .resp(dResp));

  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Attributes are not judged on a fault answer.
  task automatic chk_resp(input string what, input mmu_pkg::resp_s exp, input mmu_pkg::resp_s got);
    cmp_count++;
    if (exp.miss | exp.addrErr)
      got.attr = exp.attr;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [63:0] exp, input string what);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(what, exp, regRdata);
  endtask : rd

  task automatic mode_is(input mmu_pkg::mode_e m);
    #1;
    chk("privMode", {62'h0, m}, {62'h0, privMode});
  endtask : mode_is

  // Fault bit 0 is a miss, bit 1 an address error.
  task automatic xl(input bit fetch, input logic [63:0] va, input logic [35:0] pa, input logic [2:0] at,
                    input logic [1:0] fault);
    mmu_pkg::resp_s r;
    if (fetch)
      fetchPipe.go(va, r);
    else
      dataPipe.go(va, r);
    chk_resp(fetch ? "iResp" : "dResp", '{1'b1, pa, at, fault[0], fault[1]}, r);
  endtask : xl

  function automatic logic [63:0] lo(input logic [23:0] pfn, input logic [2:0] at, input logic g);
    return {34'h0, pfn, at, 1'b1, 1'b1, g};
  endfunction : lo

  task automatic t_unmapped();
    xl(0, 64'hffffffff80001234, 36'h000001234, `ATTR_WRITEBACK, 2'b00);
    xl(0, 64'hffffffffa0012345, 36'h000012345, `ATTR_UNCACHED, 2'b00);
    xl(1, 64'hffffffff9fffffff, 36'h01fffffff, `ATTR_WRITEBACK, 2'b00);
  endtask : t_unmapped

  task automatic t_regs();
    rd(`OFF_MODE, 64'h0, "mode");
    rd(4'hf, 64'h0, "unmapped");
    wr(`OFF_LOCKED, 64'h3f);
    rd(`OFF_RANDOM, 64'h3f, "random");
  endtask : t_regs

  task automatic t_small_page();
    xl(0, 64'h40000abc, 36'h0, 3'h0, 2'b01);
    wr(`OFF_PAGE_SIZE_MASK_REG, 64'h0);
    wr(`OFF_ENTRY_HIGH_REG, 64'h40000005);
    wr(`OFF_LO0, lo(24'h012345, `ATTR_WRITEBACK, 1'b0));
    wr(`OFF_LO1, lo(24'h054321, `ATTR_ACCEL, 1'b0));
    wr(`OFF_INDEX, 64'h3);
    wr(`OFF_COMMAND, 64'h1);
    xl(0, 64'h40000abc, 36'h012345abc, `ATTR_WRITEBACK, 2'b00);
    xl(0, 64'h40001abc, 36'h054321abc, `ATTR_ACCEL, 2'b00);
    xl(1, 64'h40000abc, 36'h012345abc, `ATTR_WRITEBACK, 2'b00);
    xl(1, 64'h40000def, 36'h012345def, `ATTR_WRITEBACK, 2'b00);
    wr(`OFF_ENTRY_HIGH_REG, 64'h40000006);
    xl(0, 64'h40000abc, 36'h0, 3'h0, 2'b01);
    xl(1, 64'h40000abc, 36'h0, 3'h0, 2'b01);
  endtask : t_small_page

  task automatic t_large_page();
    wr(`OFF_PAGE_SIZE_MASK_REG, 64'h1ffe000);
    wr(`OFF_ENTRY_HIGH_REG, 64'h08000009);
    wr(`OFF_LO0, lo(24'habc000, `ATTR_UNCACHED, 1'b1));
    wr(`OFF_LO1, lo(24'hdef000, `ATTR_WRITEBACK, 1'b1));
    wr(`OFF_COMMAND, 64'h2);
    wr(`OFF_ENTRY_HIGH_REG, 64'h08000001);
    xl(0, 64'h08123456, 36'habc123456, `ATTR_UNCACHED, 2'b00);
    xl(0, 64'h09fedcba, 36'hdeffedcba, `ATTR_WRITEBACK, 2'b00);
    wr(`OFF_INDEX, 64'h3f);
    wr(`OFF_COMMAND, 64'h4);
    rd(`OFF_LO0, lo(24'habc000, `ATTR_UNCACHED, 1'b1), "lo0");
    rd(`OFF_PAGE_SIZE_MASK_REG, 64'h1ffe000, "page_size_mask_reg");
  endtask : t_large_page

  task automatic t_modes();
    wr(`OFF_STATUS, 64'h16);
    mode_is(mmu_pkg::MODE_KERNEL);
    wr(`OFF_STATUS, 64'h12);
    mode_is(mmu_pkg::MODE_KERNEL);
    wr(`OFF_STATUS, 64'h10);
    mode_is(mmu_pkg::MODE_USER);
    xl(0, 64'h0000010000000000, 36'h0, 3'h0, 2'b10);
    xl(0, 64'h08123456, 36'habc123456, `ATTR_UNCACHED, 2'b00);
    wr(`OFF_STATUS, 64'h0);
    mode_is(mmu_pkg::MODE_USER);
    do_reset();
    mode_is(mmu_pkg::MODE_KERNEL);
    wr(`OFF_STATUS, 64'h8);
    mode_is(mmu_pkg::MODE_SUPER);
  endtask : t_modes

  initial
  begin
    do_reset();
    t_unmapped();
    t_regs();
    t_small_page();
    t_large_page();
    t_modes();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done();
  end

endmodule : virtual_address_translation_bench
